// ==== rtl/wwd_core.sv ====
/*
 * Window watchdog core: power-on hold, sync monitoring, windowed kick
 * policing, reset pulse generation and stuck-kick detection.
 * Assumes synchronous inputs and a power-good level from supply monitors.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wwd_params.svh"

module wwd_core #(
    parameter int TICK_CYC = `WWD_TICK_CYC,
    parameter int KICK_MAX_CYC = `WWD_KICK_MAX_CYC,
    parameter logic [15:0] T_POR = 16'(`WWD_T_POR),
    parameter logic [15:0] T_SYNC = 16'(`WWD_T_SYNC),
    parameter logic [15:0] T_SCLOSE = 16'(`WWD_T_SCLOSE),
    parameter logic [15:0] T_SOPEN = 16'(`WWD_T_SOPEN),
    parameter logic [15:0] T_LCLOSE = 16'(`WWD_T_LCLOSE),
    parameter logic [15:0] T_LOPEN = 16'(`WWD_T_LOPEN),
    parameter logic [15:0] T_RST = 16'(`WWD_T_RST)
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic POWER_GOOD,
    input wire logic KICK_INPUT,
    input wire logic MODE,
    input wire logic GUARD_DISABLE_N,
    output logic WATCHDOG_RESET_OUTPUT,
    output logic VALID_KICK_PULSE
);

    localparam logic [22:0] KICK_MIN = 23'(`WWD_KICK_MIN_CYC);
    localparam logic [22:0] KICK_MAX = 23'(KICK_MAX_CYC);
    localparam logic [22:0] TICK_LAST = 23'(TICK_CYC - 1);

    // Closed window length of the active mode.
    function automatic logic [15:0] close_len(input logic long_mode);
        close_len = long_mode ? T_LCLOSE : T_SCLOSE;
    endfunction

    // Open window length of the active mode.
    function automatic logic [15:0] open_len(input logic long_mode);
        open_len = long_mode ? T_LOPEN : T_SOPEN;
    endfunction

    wwd_pkg::wwd_state_t state, next_state;
    logic [22:0] tick_cnt, next_tick_cnt;
    logic [15:0] ivl_cnt, next_ivl_cnt;
    logic [22:0] low_cnt, next_low_cnt;
    logic kick_prev, next_kick_prev;
    logic stuck, next_stuck;
    logic out_n, next_out_n;
    logic valid, next_valid;
    logic tick;
    logic kick_ok;
    logic kick_rise;
    logic ivl_done;

    // Timebase tick, kick edge detection and interval end.
    assign tick = (tick_cnt == TICK_LAST);
    assign kick_rise = KICK_INPUT && !kick_prev;
    // A valid kick is a low pulse of legal width ending on a rising edge.
    assign kick_ok = kick_rise && (low_cnt >= KICK_MIN) && !stuck;
    assign ivl_done = tick && (ivl_cnt <= 16'h0001);

    // Kick pulse width measurement and stuck-low detection.
    always_comb begin
        next_kick_prev = KICK_INPUT;
        next_low_cnt = low_cnt;
        next_stuck = stuck;
        next_valid = kick_ok;
        if (KICK_INPUT) begin
            next_low_cnt = 23'h0;
            next_stuck = 1'b0;
        end else if (low_cnt < KICK_MAX) begin
            next_low_cnt = low_cnt + 23'h1;
        end else begin
            next_stuck = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            kick_prev <= 1'b1;
            low_cnt <= 23'h0;
            stuck <= 1'b0;
            valid <= 1'b0;
        end else begin
            kick_prev <= next_kick_prev;
            low_cnt <= next_low_cnt;
            stuck <= next_stuck;
            valid <= next_valid;
        end
    end

    // Sequencer: the timebase and the interval counter restart per state.
    always_comb begin
        next_state = state;
        next_tick_cnt = tick ? 23'h0 : tick_cnt + 23'h1;
        next_ivl_cnt = tick ? ivl_cnt - 16'h1 : ivl_cnt;
        next_out_n = 1'b1;
        case (state)
            wwd_pkg::ST_POR: begin
                next_out_n = 1'b0;
                if (!POWER_GOOD) begin
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = T_POR;
                end else if (ivl_done) begin
                    next_state = wwd_pkg::ST_SYNC;
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = T_SYNC;
                    next_out_n = 1'b1;
                end
            end
            wwd_pkg::ST_SYNC: begin
                if (kick_ok) begin
                    next_state = wwd_pkg::ST_CLOSE;
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = close_len(MODE);
                end else if (ivl_done) begin
                    next_state = wwd_pkg::ST_RESET;
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = T_RST;
                    next_out_n = 1'b0;
                end
            end
            wwd_pkg::ST_CLOSE: begin
                if (kick_ok) begin
                    next_state = wwd_pkg::ST_RESET;
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = T_RST;
                    next_out_n = 1'b0;
                end else if (ivl_done) begin
                    next_state = wwd_pkg::ST_OPEN;
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = open_len(MODE);
                end
            end
            wwd_pkg::ST_OPEN: begin
                if (kick_ok) begin
                    next_state = wwd_pkg::ST_CLOSE;
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = close_len(MODE);
                end else if (ivl_done) begin
                    next_state = wwd_pkg::ST_RESET;
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = T_RST;
                    next_out_n = 1'b0;
                end
            end
            // A rising kick edge while low restarts the pulse timer.
            wwd_pkg::ST_RESET: begin
                next_out_n = 1'b0;
                if (kick_rise) begin
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = T_RST;
                end else if (ivl_done) begin
                    next_state = wwd_pkg::ST_SYNC;
                    next_tick_cnt = 23'h0;
                    next_ivl_cnt = T_SYNC;
                    next_out_n = 1'b1;
                end
            end
            wwd_pkg::ST_OFF: begin
                next_tick_cnt = 23'h0;
                next_ivl_cnt = T_SYNC;
                if (GUARD_DISABLE_N) begin
                    next_state = wwd_pkg::ST_SYNC;
                end
            end
            default: begin
                next_state = wwd_pkg::ST_POR;
                next_out_n = 1'b0;
            end
        endcase
        // Disable parks the sequencer released, except during power-on.
        if (!GUARD_DISABLE_N && state != wwd_pkg::ST_POR) begin
            next_state = wwd_pkg::ST_OFF;
            next_tick_cnt = 23'h0;
            next_ivl_cnt = T_SYNC;
            next_out_n = 1'b1;
        end else if (next_stuck && state != wwd_pkg::ST_POR) begin
            next_out_n = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= wwd_pkg::ST_POR;
            tick_cnt <= 23'h0;
            ivl_cnt <= T_POR;
            out_n <= 1'b0;
        end else begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            ivl_cnt <= next_ivl_cnt;
            out_n <= next_out_n;
        end
    end

    // Outputs come straight from flip-flops.
    assign WATCHDOG_RESET_OUTPUT = out_n;
    assign VALID_KICK_PULSE = valid;

    // Checks of the sequencer against its causes.
    sequence seq_early_kick;
        (state == wwd_pkg::ST_CLOSE) && kick_ok && GUARD_DISABLE_N;
    endsequence

    AST_POR_LOW: assert property (@(posedge CLK) disable iff (!RST_N)
        state == wwd_pkg::ST_POR |-> !out_n)
        else $error("Reset output released during power-on hold.");
    AST_POR_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
        (state == wwd_pkg::ST_POR) && !POWER_GOOD |=>
        state == wwd_pkg::ST_POR)
        else $error("Power-on hold left before power good.");
    AST_SYNC_KICK: assert property (@(posedge CLK) disable iff (!RST_N)
        (state == wwd_pkg::ST_SYNC) && kick_ok && GUARD_DISABLE_N |=>
        state == wwd_pkg::ST_CLOSE && ivl_cnt == close_len($past(MODE)))
        else $error("Sync kick did not open a closed window.");
    AST_SYNC_TMO: assert property (@(posedge CLK) disable iff (!RST_N)
        (state == wwd_pkg::ST_SYNC) && ivl_done && !kick_ok &&
        GUARD_DISABLE_N |=> !out_n ##0 state == wwd_pkg::ST_RESET)
        else $error("Sync timeout gave no reset pulse.");
    AST_EARLY: assert property (@(posedge CLK) disable iff (!RST_N)
        seq_early_kick |=> state == wwd_pkg::ST_RESET ##1 !out_n)
        else $error("Early kick gave no reset.");
    AST_OPEN_KICK: assert property (@(posedge CLK) disable iff (!RST_N)
        (state == wwd_pkg::ST_OPEN) && kick_ok && GUARD_DISABLE_N |=>
        state == wwd_pkg::ST_CLOSE)
        else $error("Open window kick did not restart closed window.");
    AST_MISS: assert property (@(posedge CLK) disable iff (!RST_N)
        (state == wwd_pkg::ST_OPEN) && ivl_done && !kick_ok &&
        GUARD_DISABLE_N |=> state == wwd_pkg::ST_RESET)
        else $error("Missed kick gave no reset.");
    AST_DISABLE: assert property (@(posedge CLK) disable iff (!RST_N)
        !GUARD_DISABLE_N && state != wwd_pkg::ST_POR |=> out_n [*2])
        else $error("Reset output low while disabled.");
    AST_STUCK: assert property (@(posedge CLK) disable iff (!RST_N)
        stuck && !KICK_INPUT && GUARD_DISABLE_N |=> !out_n)
        else $error("Stuck kick did not hold reset.");
    AST_RESTART: assert property (@(posedge CLK) disable iff (!RST_N)
        (state == wwd_pkg::ST_RESET) && kick_rise && GUARD_DISABLE_N |=>
        state == wwd_pkg::ST_RESET && ivl_cnt == T_RST)
        else $error("Kick during reset did not restart the pulse.");
    AST_TICK: assert property (@(posedge CLK) disable iff (!RST_N)
        tick_cnt <= TICK_LAST)
        else $error("Timebase counter overran its period.");

    // A valid kick inside the open window.
    sequence seq_open_kick;
        (state == wwd_pkg::ST_OPEN) && kick_ok && GUARD_DISABLE_N;
    endsequence

    // A running reset pulse with no kick, no end and no disable.
    sequence seq_pulse_run;
        (state == wwd_pkg::ST_RESET) && !kick_rise && !ivl_done &&
        GUARD_DISABLE_N;
    endsequence

    // An early kick loads a full reset pulse and pulls the output low.
    AST_LEARLY: assert property (@(posedge CLK) disable iff (!RST_N)
        seq_early_kick |=> ivl_cnt == T_RST && !out_n)
        else $error("Early kick did not load a reset pulse.");

    // An open window kick rearms the closed window of the active mode.
    AST_REARM: assert property (@(posedge CLK) disable iff (!RST_N)
        seq_open_kick |=> out_n && ivl_cnt == close_len($past(MODE)))
        else $error("Open window kick loaded a wrong closed window.");

    // The open window length follows the mode at the window change.
    AST_OPEN_LEN: assert property (@(posedge CLK) disable iff (!RST_N)
        (state == wwd_pkg::ST_CLOSE) && ivl_done && !kick_ok &&
        GUARD_DISABLE_N |=> state == wwd_pkg::ST_OPEN &&
        ivl_cnt == open_len($past(MODE)))
        else $error("Open window length does not follow the mode.");

    // Every valid kick shows one strobe on the next cycle.
    AST_VALID: assert property (@(posedge CLK) disable iff (!RST_N)
        kick_ok |=> valid)
        else $error("Valid kick gave no strobe.");

    // The reset pulse holds the output low until its interval ends.
    AST_PULSE: assert property (@(posedge CLK) disable iff (!RST_N)
        seq_pulse_run |=> state == wwd_pkg::ST_RESET && !out_n)
        else $error("Reset pulse ended early.");

    // Enabling again restarts sync monitoring with a full timeout.
    AST_ENABLE: assert property (@(posedge CLK) disable iff (!RST_N)
        (state == wwd_pkg::ST_OFF) && GUARD_DISABLE_N |=>
        state == wwd_pkg::ST_SYNC && ivl_cnt == T_SYNC)
        else $error("Enable did not restart sync monitoring.");

endmodule

`default_nettype wire

// ==== rtl/wwd_params.svh ====
/*
 * Timing constants of the window watchdog.
 * Assumes a 125 MHz core clock; intervals count timebase ticks.
 */
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

// Core clock period in ns.
`define WWD_CLK_NS 8
// Kick pulse width limits, in ns, as printed (10 us and 5 ms).
`define WWD_KICK_MIN_NS 10000
`define WWD_KICK_MAX_NS 5000000
// Least kick width rounds up, longest rounds down.
`define WWD_KICK_MIN_CYC ((`WWD_KICK_MIN_NS + `WWD_CLK_NS - 1) / `WWD_CLK_NS)
`define WWD_KICK_MAX_CYC (`WWD_KICK_MAX_NS / `WWD_CLK_NS)
// Default timebase period in core cycles (about 0.88 ms).
`define WWD_TICK_CYC 110000
// Default interval lengths in timebase ticks.
`define WWD_T_POR 16
`define WWD_T_SYNC 64
`define WWD_T_SCLOSE 8
`define WWD_T_SOPEN 8
`define WWD_T_LCLOSE 32
`define WWD_T_LOPEN 32
`define WWD_T_RST 4

`endif

// ==== rtl/wwd_pkg.sv ====
/*
 * Types of the window watchdog.
 * Assumes nothing of its surroundings.
 */
package wwd_pkg;
    typedef enum logic [2:0] {
        ST_POR,
        ST_SYNC,
        ST_CLOSE,
        ST_OPEN,
        ST_RESET,
        ST_OFF
    } wwd_state_t;
endpackage

// ==== testbench/window_watchdog_bench.sv ====
/*
 * Self-checking bench of the window watchdog core with short intervals.
 * Assumes a 10-cycle timebase and a stuck-kick limit of 2000 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_bench;
    localparam int POR = 40, SYNC = 3000, SC = 1500, SO = 1500;
    localparam int RST = 200, KL = 1300;
    localparam int TB_TICK = 10, TB_KMAX = 2000;
    localparam logic [15:0] TP = 16'h0004, TS = 16'h012c, TC = 16'h0096;
    localparam logic [15:0] TL = 16'h012c, TR = 16'h0014;
    logic clk = 1'b0, rst_n = 1'b0, power_good = 1'b0;
    logic mode = 1'b0, guard_n = 1'b1;
    logic kick, watchdog_reset_output, valid, ok;
    int num_errors = 0, samples_checked = 0, nvalid = 0, lows = 0, n, l;

    // Clock at 125 MHz.
    always #4 clk = ~clk;

    wwd_core #(.TICK_CYC(TB_TICK), .KICK_MAX_CYC(TB_KMAX), .T_POR(TP),
        .T_SYNC(TS), .T_SCLOSE(TC), .T_SOPEN(TC),
        .T_LCLOSE(TL), .T_LOPEN(TL), .T_RST(TR)
    ) wwd_core_i (.CLK(clk), .RST_N(rst_n), .POWER_GOOD(power_good),
        .KICK_INPUT(kick), .MODE(mode), .GUARD_DISABLE_N(guard_n),
        .WATCHDOG_RESET_OUTPUT(watchdog_reset_output), .VALID_KICK_PULSE(valid));
    wwd_mcu_model wwd_mcu_model_i (.CLK(clk), .KICK_INPUT(kick));

    // Counts valid-kick pulses and cycles with the reset output low.
    always @(negedge clk) begin
        if (valid === 1'b1) nvalid++;
        if (watchdog_reset_output === 1'b0) lows++;
    end

    task automatic check(input logic seen, input logic exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask

    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Waits on falling edges until the reset output shows a level.
    task automatic wait_wdo(input logic lvl, input int max, output int c);
        c = 0;
        while (watchdog_reset_output !== lvl && c < max) begin
            @(negedge clk);
            c++;
        end
    endtask

    // Measures a reset pulse that has just begun.
    task automatic pulse_ok();
        int c;
        wait_wdo(1'b1, RST + 40, c);
        check(c >= RST - 10 && c <= RST + 10, 1'b1, "pulse length");
    endtask

    // Waits, kicks once and reports whether one valid pulse was seen.
    task automatic kick_v(input int pre, output logic v);
        int b;
        repeat (pre) @(negedge clk);
        b = nvalid;
        wwd_mcu_model_i.kick(KL);
        repeat (4) @(negedge clk);
        v = (nvalid == b + 1);
    endtask

    task automatic t_por();
        @(negedge clk);
        check(watchdog_reset_output, 1'b0, "low in reset");
        @(posedge clk) power_good <= 1'b1;
        repeat (POR - 5) @(negedge clk);
        check(watchdog_reset_output, 1'b0, "hold too short");
        wait_wdo(1'b1, 20, n);
        check(watchdog_reset_output, 1'b1, "hold not released");
    endtask

    task automatic t_sync();
        wait_wdo(1'b0, SYNC + 50, n);
        check(n >= SYNC - 20 && watchdog_reset_output === 1'b0, 1'b1, "sync timeout");
        pulse_ok();
        kick_v(0, ok);
        check(ok, 1'b1, "sync kick");
    endtask

    task automatic t_short();
        l = lows;
        repeat (2) begin
            kick_v(400, ok);
            check(ok && lows == l, 1'b1, "open kick");
        end
        kick_v(0, ok);
        check(watchdog_reset_output, 1'b0, "early kick");
        pulse_ok();
        kick_v(0, ok);
        wait_wdo(1'b0, SC + SO + 50, n);
        check(n >= SC + SO - 20 && watchdog_reset_output === 1'b0, 1'b1, "miss");
        pulse_ok();
    endtask

    task automatic t_long();
        @(posedge clk) mode <= 1'b1;
        kick_v(0, ok);
        kick_v(400, ok);
        check(watchdog_reset_output, 1'b0, "long early kick");
        pulse_ok();
        kick_v(0, ok);
        l = lows;
        kick_v(1900, ok);
        check(ok && lows == l, 1'b1, "long open kick");
        @(posedge clk) mode <= 1'b0;
        kick_v(1900, ok);
        kick_v(400, ok);
        check(ok && lows == l, 1'b1, "mode switch");
    endtask

    task automatic t_stuck();
        fork
            wwd_mcu_model_i.kick(2500);
            begin
                repeat (2200) @(negedge clk);
                check(watchdog_reset_output, 1'b0, "stuck kick");
            end
        join
        repeat (3) @(negedge clk);
        check(watchdog_reset_output, 1'b1, "stuck release");
        wait_wdo(1'b0, 700, n);
        wait_wdo(1'b1, 400, n);
    endtask

    task automatic t_stretch();
        wait_wdo(1'b0, SYNC + 50, n);
        wwd_mcu_model_i.kick(50);
        check(watchdog_reset_output, 1'b0, "pulse not stretched");
        wait_wdo(1'b1, RST + 40, n);
        check(n >= RST - 10, 1'b1, "timer not restarted");
    endtask

    task automatic t_disable();
        @(posedge clk) guard_n <= 1'b0;
        l = lows;
        repeat (SYNC + 500) @(negedge clk);
        check(lows == l && watchdog_reset_output === 1'b1, 1'b1, "disabled");
        @(posedge clk) guard_n <= 1'b1;
        wait_wdo(1'b0, SYNC + 600, n);
        check(watchdog_reset_output, 1'b0, "enabled again");
    endtask

    // Main sequence: reset for two cycles, then each scenario in turn.
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_por();
        t_sync();
        t_short();
        t_long();
        t_stuck();
        t_stretch();
        t_disable();
        conclude();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire

// ==== testbench/wwd_mcu_model.sv ====
/*
 * Model of the supervised controller: makes kick pulses on request.
 * Assumes the bench calls kick from its main thread only.
 */
`timescale 1ns/1ps
`default_nettype none
module wwd_mcu_model (
    input wire logic CLK,
    output logic KICK_INPUT
);
    // The kick line idles high between pulses.
    initial KICK_INPUT = 1'b1;

    // Holds the line low for the given cycles, then releases it.
    task automatic kick(input int low);
        @(posedge CLK);
        KICK_INPUT <= 1'b0;
        repeat (low) @(posedge CLK);
        KICK_INPUT <= 1'b1;
        @(negedge CLK);
    endtask
endmodule
`default_nettype wire
